// ---- common/i2cr_defines.svh ----
// Purpose: register offsets, field positions and reset values of the two-wire controller
// Assumes: 3-bit register index on the plain register port
// Notes: definitions only
`ifndef I2CR_DEFINES_SVH
`define I2CR_DEFINES_SVH

// register offsets
`define I2CR_OFS_OWN_ADDR 3'h0
`define I2CR_OFS_RATE_DIV 3'h1
`define I2CR_OFS_CTRL 3'h2
`define I2CR_OFS_STAT 3'h3
`define I2CR_OFS_DATA 3'h4
`define I2CR_OFS_MASK 3'h5
`define I2CR_OFS_SYS_OPT 3'h6

// control register fields
`define I2CR_CTRL_EN 7
`define I2CR_CTRL_MST 5
`define I2CR_CTRL_TX 4
`define I2CR_CTRL_TXAK 3
`define I2CR_CTRL_RSTA 2

// divider register fields
`define I2CR_DIV_RATE_FACTOR_FIELD_HI 7
`define I2CR_DIV_RATE_FACTOR_FIELD_LO 6
`define I2CR_DIV_RATE_HI 5
`define I2CR_DIV_RATE_LO 0

// interrupt status and mask bits
`define I2CR_INT_BYTE 0
`define I2CR_INT_ARB 1
`define I2CR_INT_ADDR 2
`define I2CR_INT_STOP 3

// system option register field
`define I2CR_OPT_PPS 0

// reset values
`define I2CR_RST_OWN_ADDR 7'h00
`define I2CR_RST_RATE_DIV 8'h00
`define I2CR_RST_MASK 4'h0

// bits per byte plus acknowledge slot
`define I2CR_ACK_SLOT 4'h8
`define I2CR_BYTE_END 4'h9
// clocks from a pin edge to the edge detector
`define I2CR_SYNC_LAG 14'h0003

`endif

// ---- common/i2cr_pkg.sv ----
// Purpose: types of the two-wire controller
// Assumes: constants come from i2cr_defines.svh
// Notes: the whole controller state is one packed struct
package i2cr_pkg;

   typedef enum logic [2:0] {
      M_IDLE,
      M_START,
      M_LOW,
      M_HIGH,
      M_STOP1,
      M_STOP2,
      M_RSTART,
      M_RS2
   } i2cr_mstate_t;

   typedef struct packed {
      logic [6:0] own_addr;
      logic [7:0] rate_div;
      logic en;
      logic mst;
      logic tx;
      logic txak;
      logic pps;
      logic [3:0] mask;
      logic [3:0] ints;
      logic [7:0] tx_data;
      logic [7:0] rx_data;
      logic [7:0] rdata;
      logic rxak;
      logic busy;
      logic addressed;
      logic srw;
      logic addr_phase;
      logic stall;
      logic [3:0] bitcnt;
      i2cr_mstate_t mstate;
      logic [13:0] cnt;
      logic [13:0] hold_cnt;
      logic hold_run;
      logic sda_pend;
      logic sda_low;
      logic scl_low;
      logic stop_req;
      logic rsta_req;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic scl_m;
      logic scl_s;
      logic scl_p;
   } i2cr_state_t;

endpackage

// ---- hw/i2cr_ctrl.sv ----
// Purpose: multi-master two-wire controller with rate divider and own address
// Assumes: 40 MHz clk, registers on a plain port, pins synchronised inside
// Notes: Summary of operation below
//
// Summary of operation
// [R1] rates up to clock over twenty; the code reaches clock over 22, as each high phase adds 2 clocks of sync lag
// [R2] option bit picks default or alternate pins
// [R3] keeps running in wait, interrupt wakes
// [R4] light stop freezes, registers unchanged
// [R5] deep stop returns registers to reset
// [R6] six-bit code selects one of 64 settings
// [R7] two-bit factor gives 1, 2 or 4
// [R8] rate is clock over factor times divider; the code adds 2 clocks of sync lag to each high phase
// [R9] data changes hold time after clock falls
// [R10] start hold before driving clock low
// [R11] stop hold before data rises
// [R12] seven-bit own address matched
// [R13] arbitration loss interrupts, drops to slave
// [R14] start, stop, repeated start generated and detected
// [R15] software acknowledge, received acknowledge captured
// [R16] byte transfers, interrupt after each byte
// [R17] table gives divider and three holds
`timescale 1ns/1ps
`include "i2cr_defines.svh"

module i2cr_ctrl
   import i2cr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   input wire logic stop_light,
   input wire logic stop_deep,
   input wire logic sda0_in,
   output logic sda0_out,
   output logic sda0_oe_n,
   input wire logic scl0_in,
   output logic scl0_out,
   output logic scl0_oe_n,
   input wire logic sda1_in,
   output logic sda1_out,
   output logic sda1_oe_n,
   input wire logic scl1_in,
   output logic scl1_out,
   output logic scl1_oe_n
);

   localparam i2cr_state_t I2CR_RST = '{
      own_addr: `I2CR_RST_OWN_ADDR,
      rate_div: `I2CR_RST_RATE_DIV,
      mask: `I2CR_RST_MASK,
      mstate: M_IDLE,
      sda_m: 1'b1,
      sda_s: 1'b1,
      sda_p: 1'b1,
      scl_m: 1'b1,
      scl_s: 1'b1,
      scl_p: 1'b1,
      default: '0
   };

   i2cr_state_t state_reg;
   i2cr_state_t state_next;

   logic [47:0] lut;
   logic [1:0] mul_sh;
   logic [13:0] div_cyc;
   logic [13:0] half_cyc;
   logic [13:0] sdah_cyc;
   logic [13:0] starth_cyc;
   logic [13:0] stoph_cyc;
   logic sda_in;
   logic scl_in;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic arb_lost;
   logic [3:0] ev;

   // {divider, data hold, start hold, stop hold}, 12 bits each
   function automatic logic [47:0] rate_lut(input logic [5:0] code);
      case (code)
         6'h00: rate_lut = 48'h014_007_006_00B;
         6'h01: rate_lut = 48'h016_007_007_00C;
         6'h02: rate_lut = 48'h018_008_008_00D;
         6'h03: rate_lut = 48'h01A_008_009_00E;
         6'h04: rate_lut = 48'h01C_009_00A_00F;
         6'h05: rate_lut = 48'h01E_009_00B_010;
         6'h06: rate_lut = 48'h022_00A_00D_012;
         6'h07: rate_lut = 48'h028_00A_010_015;
         6'h08: rate_lut = 48'h01C_007_00A_00F;
         6'h09: rate_lut = 48'h020_007_00C_011;
         6'h0A: rate_lut = 48'h024_009_00E_013;
         6'h0B: rate_lut = 48'h028_009_010_015;
         6'h0C: rate_lut = 48'h02C_00B_012_017;
         6'h0D: rate_lut = 48'h030_00B_014_019;
         6'h0E: rate_lut = 48'h038_00D_018_01D;
         6'h0F: rate_lut = 48'h044_00D_01E_023;
         6'h10: rate_lut = 48'h030_009_012_019;
         6'h11: rate_lut = 48'h038_009_016_01D;
         6'h12: rate_lut = 48'h040_00D_01A_021;
         6'h13: rate_lut = 48'h048_00D_01E_025;
         6'h14: rate_lut = 48'h050_011_022_029;
         6'h15: rate_lut = 48'h058_011_026_02D;
         6'h16: rate_lut = 48'h068_015_02E_035;
         6'h17: rate_lut = 48'h080_015_03A_041;
         6'h18: rate_lut = 48'h050_009_026_029;
         6'h19: rate_lut = 48'h060_009_02E_031;
         6'h1A: rate_lut = 48'h070_011_036_039;
         6'h1B: rate_lut = 48'h080_011_03E_041;
         6'h1C: rate_lut = 48'h090_019_046_049;
         6'h1D: rate_lut = 48'h0A0_019_04E_051;
         6'h1E: rate_lut = 48'h0C0_021_05E_061;
         6'h1F: rate_lut = 48'h0F0_021_076_079;
         6'h20: rate_lut = 48'h0A0_011_04E_051;
         6'h21: rate_lut = 48'h0C0_011_05E_061;
         6'h22: rate_lut = 48'h0E0_021_06E_071;
         6'h23: rate_lut = 48'h100_021_07E_081;
         6'h24: rate_lut = 48'h120_031_08E_091;
         6'h25: rate_lut = 48'h140_031_09E_0A1;
         6'h26: rate_lut = 48'h180_041_0BE_0C1;
         6'h27: rate_lut = 48'h1E0_041_0EE_0F1;
         6'h28: rate_lut = 48'h140_021_09E_0A1;
         6'h29: rate_lut = 48'h180_021_0BE_0C1;
         6'h2A: rate_lut = 48'h1C0_041_0DE_0E1;
         6'h2B: rate_lut = 48'h200_041_0FE_101;
         6'h2C: rate_lut = 48'h240_061_11E_121;
         6'h2D: rate_lut = 48'h280_061_13E_141;
         6'h2E: rate_lut = 48'h300_081_17E_181;
         6'h2F: rate_lut = 48'h3C0_081_1DE_1E1;
         6'h30: rate_lut = 48'h280_041_13E_141;
         6'h31: rate_lut = 48'h300_041_17E_181;
         6'h32: rate_lut = 48'h380_081_1BE_1C1;
         6'h33: rate_lut = 48'h400_081_1FE_201;
         6'h34: rate_lut = 48'h480_0C1_23E_241;
         6'h35: rate_lut = 48'h500_0C1_27E_281;
         6'h36: rate_lut = 48'h600_101_2FE_301;
         6'h37: rate_lut = 48'h780_101_3BE_3C1;
         6'h38: rate_lut = 48'h500_081_27E_281;
         6'h39: rate_lut = 48'h600_081_2FE_301;
         6'h3A: rate_lut = 48'h700_101_37E_381;
         6'h3B: rate_lut = 48'h800_101_3FE_401;
         6'h3C: rate_lut = 48'h900_181_47E_481;
         6'h3D: rate_lut = 48'hA00_181_4FE_501;
         6'h3E: rate_lut = 48'hC00_201_5FE_601;
         default: rate_lut = 48'hF00_201_77E_781;
      endcase
   endfunction

   // smallest divider is 20 clocks, but the high phase waits 2 more for the synchronised line, so the fastest bit is clk/22
   assign lut = rate_lut(state_reg.rate_div[`I2CR_DIV_RATE_HI:`I2CR_DIV_RATE_LO]); // [R6] [R17] [R1]

   always_comb begin
      case (state_reg.rate_div[`I2CR_DIV_RATE_FACTOR_FIELD_HI:`I2CR_DIV_RATE_FACTOR_FIELD_LO]) // [R7]
         2'h1: mul_sh = 2'h1;
         2'h2: mul_sh = 2'h2;
         default: mul_sh = 2'h0;
      endcase
   end

   // every time figure is scaled by the rate factor
   assign div_cyc = {2'h0, lut[47:36]} << mul_sh; // [R8]
   assign half_cyc = div_cyc >> 1;
   assign sdah_cyc = {2'h0, lut[35:24]} << mul_sh; // [R9]
   assign starth_cyc = {2'h0, lut[23:12]} << mul_sh; // [R10]
   assign stoph_cyc = {2'h0, lut[11:0]} << mul_sh; // [R11]

   assign sda_in = state_reg.pps ? sda1_in : sda0_in; // [R2]
   assign scl_in = state_reg.pps ? scl1_in : scl0_in; // [R2]

   assign scl_rise = state_reg.scl_s & ~state_reg.scl_p;
   assign scl_fall = ~state_reg.scl_s & state_reg.scl_p;
   assign start_det = state_reg.scl_s & state_reg.sda_p & ~state_reg.sda_s; // [R14]
   assign stop_det = state_reg.scl_s & ~state_reg.sda_p & state_reg.sda_s; // [R14]

   // lost when we release data but the line reads low
   assign arb_lost = state_reg.en & state_reg.mst & scl_rise & state_reg.tx
      & (state_reg.bitcnt < `I2CR_ACK_SLOT) & ~state_reg.sda_low & ~state_reg.sda_s; // [R13]

   always_comb begin
      state_next = state_reg;
      ev = 4'h0;
      state_next.sda_m = sda_in;
      state_next.sda_s = state_reg.sda_m;
      state_next.sda_p = state_reg.sda_s;
      state_next.scl_m = scl_in;
      state_next.scl_s = state_reg.scl_m;
      state_next.scl_p = state_reg.scl_s;
      state_next.rdata = 8'h00;

      if (reg_rd) begin
         case (reg_addr)
            `I2CR_OFS_OWN_ADDR: state_next.rdata = {state_reg.own_addr, 1'b0};
            `I2CR_OFS_RATE_DIV: state_next.rdata = state_reg.rate_div;
            `I2CR_OFS_CTRL: state_next.rdata = {state_reg.en, 1'b0, state_reg.mst,
               state_reg.tx, state_reg.txak, 3'h0};
            `I2CR_OFS_STAT: state_next.rdata = {state_reg.busy, state_reg.addressed,
               state_reg.srw, state_reg.rxak, state_reg.ints};
            `I2CR_OFS_DATA: begin
               state_next.rdata = state_reg.rx_data;
               if (!state_reg.tx) begin
                  state_next.stall = 1'b0; // [R16]
               end
            end
            `I2CR_OFS_MASK: state_next.rdata = {4'h0, state_reg.mask};
            `I2CR_OFS_SYS_OPT: state_next.rdata = {7'h00, state_reg.pps};
            default: state_next.rdata = 8'h00;
         endcase
      end

      if (reg_wr) begin
         case (reg_addr)
            `I2CR_OFS_OWN_ADDR: state_next.own_addr = reg_wdata[7:1]; // [R12]
            `I2CR_OFS_RATE_DIV: state_next.rate_div = reg_wdata; // [R6] [R7]
            `I2CR_OFS_CTRL: begin
               state_next.en = reg_wdata[`I2CR_CTRL_EN];
               state_next.tx = reg_wdata[`I2CR_CTRL_TX];
               state_next.txak = reg_wdata[`I2CR_CTRL_TXAK]; // [R15]
               if (reg_wdata[`I2CR_CTRL_MST] && !state_reg.mst) begin
                  if (state_reg.busy) begin
                     ev[`I2CR_INT_ARB] = 1'b1; // [R13]
                  end else begin
                     state_next.mst = 1'b1; // [R14]
                     state_next.mstate = M_START;
                     state_next.sda_low = 1'b1;
                     state_next.cnt = 14'h0000;
                  end
               end
               if (!reg_wdata[`I2CR_CTRL_MST] && state_reg.mst) begin
                  state_next.stop_req = 1'b1; // [R14]
               end
               if (reg_wdata[`I2CR_CTRL_RSTA] && state_reg.mst) begin
                  state_next.rsta_req = 1'b1; // [R14]
               end
            end
            `I2CR_OFS_STAT: state_next.ints = state_reg.ints & ~reg_wdata[3:0];
            `I2CR_OFS_DATA: begin
               state_next.tx_data = reg_wdata;
               if (state_reg.tx && state_reg.stall) begin
                  // first bit goes out at once, clock is already held low
                  state_next.stall = 1'b0; // [R16]
                  state_next.sda_low = ~reg_wdata[7];
                  state_next.hold_run = 1'b0;
               end
            end
            `I2CR_OFS_MASK: state_next.mask = reg_wdata[3:0];
            `I2CR_OFS_SYS_OPT: state_next.pps = reg_wdata[`I2CR_OPT_PPS]; // [R2]
            default: state_next.ints = state_next.ints;
         endcase
      end

      // bus monitor
      if (start_det) begin
         state_next.busy = 1'b1; // [R14]
         state_next.bitcnt = 4'h0;
         state_next.addr_phase = 1'b1;
         state_next.addressed = 1'b0;
      end
      if (stop_det) begin
         state_next.busy = 1'b0; // [R14]
         state_next.addressed = 1'b0;
         state_next.addr_phase = 1'b0;
         state_next.bitcnt = 4'h0;
         ev[`I2CR_INT_STOP] = 1'b1;
      end

      // bit engine shared by master and slave
      if (state_reg.en && state_reg.busy && scl_rise) begin
         if (state_reg.bitcnt < `I2CR_ACK_SLOT) begin
            state_next.rx_data = {state_reg.rx_data[6:0], state_reg.sda_s};
         end else begin
            state_next.rxak = state_reg.sda_s; // [R15]
         end
         state_next.bitcnt = state_reg.bitcnt + 4'h1;
      end

      if (state_reg.en && state_reg.busy && scl_fall) begin
         state_next.hold_run = 1'b1; // [R9]
         state_next.hold_cnt = `I2CR_SYNC_LAG; // fall is seen this late
         state_next.sda_pend = 1'b1;
         if (state_reg.bitcnt == `I2CR_BYTE_END) begin
            state_next.bitcnt = 4'h0;
            if (state_reg.mst || state_reg.addressed) begin
               state_next.stall = 1'b1; // [R16]
               ev[`I2CR_INT_BYTE] = 1'b1; // [R16]
            end
         end else if (state_reg.bitcnt == `I2CR_ACK_SLOT) begin
            state_next.addr_phase = 1'b0;
            if (state_reg.addr_phase && !state_reg.mst
                && state_reg.rx_data[7:1] == state_reg.own_addr) begin // [R12]
               state_next.addressed = 1'b1;
               state_next.srw = state_reg.rx_data[0];
               state_next.tx = state_reg.rx_data[0];
               state_next.sda_pend = 1'b0;
               ev[`I2CR_INT_ADDR] = 1'b1;
            end else if ((state_reg.mst || state_reg.addressed) && !state_reg.tx) begin
               state_next.sda_pend = state_reg.txak; // [R15]
            end
         end else if (state_reg.bitcnt != 4'h0) begin
            if ((state_reg.mst || state_reg.addressed) && state_reg.tx) begin
               state_next.sda_pend = state_reg.tx_data[3'(4'h7 - state_reg.bitcnt)];
            end
         end else begin
            state_next.hold_run = 1'b0;
         end
      end

      if (state_reg.hold_run) begin
         if (state_reg.hold_cnt >= sdah_cyc - 14'h0001) begin
            state_next.sda_low = ~state_reg.sda_pend; // [R9]
            state_next.hold_run = 1'b0;
         end else begin
            state_next.hold_cnt = state_reg.hold_cnt + 14'h0001;
         end
      end

      // master clock and condition sequencer
      case (state_reg.mstate)
         M_START: begin
            state_next.cnt = state_reg.cnt + 14'h0001;
            if (state_reg.cnt >= starth_cyc - 14'h0001) begin
               state_next.scl_low = 1'b1; // [R10]
               state_next.mstate = M_LOW;
               state_next.cnt = 14'h0000;
               state_next.stall = 1'b1;
            end
         end
         M_LOW: begin
            if (state_reg.stall) begin
               state_next.cnt = 14'h0000;
               if (state_reg.stop_req && !state_reg.hold_run) begin
                  state_next.mstate = M_STOP1;
                  state_next.sda_low = 1'b1;
                  state_next.stop_req = 1'b0;
                  state_next.stall = 1'b0;
               end else if (state_reg.rsta_req && !state_reg.hold_run) begin
                  state_next.mstate = M_RSTART;
                  state_next.sda_low = 1'b0;
                  state_next.rsta_req = 1'b0;
                  state_next.stall = 1'b0;
               end
            end else begin
               state_next.cnt = state_reg.cnt + 14'h0001;
               if (state_reg.cnt >= half_cyc - 14'h0001) begin
                  state_next.scl_low = 1'b0; // [R8]
                  state_next.mstate = M_HIGH;
                  state_next.cnt = 14'h0000;
               end
            end
         end
         M_HIGH: begin
            if (state_reg.scl_s) begin
               state_next.cnt = state_reg.cnt + 14'h0001;
               if (state_reg.cnt >= half_cyc - 14'h0001) begin
                  state_next.scl_low = 1'b1; // [R8]
                  state_next.mstate = M_LOW;
                  state_next.cnt = 14'h0000;
               end
            end
         end
         M_STOP1, M_RSTART: begin
            state_next.cnt = state_reg.cnt + 14'h0001;
            if (state_reg.cnt >= half_cyc - 14'h0001) begin
               state_next.scl_low = 1'b0;
               state_next.mstate = (state_reg.mstate == M_STOP1) ? M_STOP2 : M_RS2;
               state_next.cnt = 14'h0000;
            end
         end
         M_STOP2: begin
            if (state_reg.scl_s) begin
               state_next.cnt = state_reg.cnt + 14'h0001;
               if (state_reg.cnt >= stoph_cyc - 14'h0001) begin
                  state_next.sda_low = 1'b0; // [R11]
                  state_next.mstate = M_IDLE;
                  state_next.mst = 1'b0;
               end
            end
         end
         M_RS2: begin
            if (state_reg.scl_s) begin
               state_next.cnt = state_reg.cnt + 14'h0001;
               if (state_reg.cnt >= half_cyc - 14'h0001) begin
                  state_next.sda_low = 1'b1; // [R14]
                  state_next.mstate = M_START;
                  state_next.cnt = 14'h0000;
               end
            end
         end
         default: state_next.cnt = 14'h0000;
      endcase

      if (arb_lost) begin
         state_next.mst = 1'b0; // [R13]
         state_next.mstate = M_IDLE;
         state_next.scl_low = 1'b0;
         state_next.sda_low = 1'b0;
         state_next.stall = 1'b0;
         state_next.hold_run = 1'b0;
         ev[`I2CR_INT_ARB] = 1'b1; // [R13]
      end

      if (!state_reg.en) begin
         state_next.mst = 1'b0;
         state_next.mstate = M_IDLE;
         state_next.scl_low = 1'b0;
         state_next.sda_low = 1'b0;
         state_next.stall = 1'b0;
         state_next.hold_run = 1'b0;
         ev = 4'h0;
      end

      // set wins over a same-cycle clear
      state_next.ints = state_next.ints | ev; // [R3]

      if (stop_light) begin
         state_next = state_reg; // [R4]
      end
      if (stop_deep) begin
         state_next = I2CR_RST; // [R5]
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= I2CR_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata = state_reg.rdata;
   assign irq = |(state_reg.ints & state_reg.mask); // [R3]

   // open drain: only ever pull low
   assign sda0_out = 1'b0;
   assign scl0_out = 1'b0;
   assign sda1_out = 1'b0;
   assign scl1_out = 1'b0;
   assign sda0_oe_n = ~(state_reg.sda_low & ~state_reg.pps); // [R2]
   assign scl0_oe_n = ~((state_reg.scl_low | state_reg.stall) & ~state_reg.pps);
   assign sda1_oe_n = ~(state_reg.sda_low & state_reg.pps); // [R2]
   assign scl1_oe_n = ~((state_reg.scl_low | state_reg.stall) & state_reg.pps);

endmodule

// ---- testbench/i2cr_properties.sv ----
// Purpose: port-level properties of the two-wire controller
// Assumes: bound to i2cr_ctrl, single clock domain
// Notes: pair-0 timing is held to lower bounds below the smallest table counts
`timescale 1ns/1ps
`include "i2cr_defines.svh"
module i2cr_properties (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic irq,
   input wire logic stop_light,
   input wire logic stop_deep,
   input wire logic sda0_oe_n,
   input wire logic scl0_oe_n,
   input wire logic sda1_oe_n,
   input wire logic scl1_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n || stop_deep);
   one_pair_a: assert property ((sda0_oe_n && scl0_oe_n) || (sda1_oe_n && scl1_oe_n))
      else $error("both pin pairs driven");
   light_freeze_a: assert property (stop_light |=> $stable({irq, sda0_oe_n, scl0_oe_n}))
      else $error("state moved in light stop");
   deep_reset_a: assert property (disable iff (!reset_n)
      stop_deep |=> !irq && sda0_oe_n && scl0_oe_n && sda1_oe_n)
      else $error("deep stop kept state");
   start_hold_a: assert property ($fell(sda0_oe_n) && scl0_oe_n |-> scl0_oe_n [*5])
      else $error("clock low too soon after start");
   sda_hold_a: assert property ($fell(scl0_oe_n) |-> $stable(sda0_oe_n) [*6])
      else $error("data moved too soon after clock fall");
   stop_hold_a: assert property ($rose(scl0_oe_n) && !sda0_oe_n |-> !sda0_oe_n [*8])
      else $error("data released too soon after clock rise");
   low_phase_a: assert property ($fell(scl0_oe_n) |-> !scl0_oe_n [*8])
      else $error("clock low phase too short");
   mask_clear_a: assert property (reg_wr && reg_addr == `I2CR_OFS_MASK
      && reg_wdata[3:0] == 4'h0 && !stop_light |=> !irq) else $error("irq while masked");
   cover property ($fell(sda0_oe_n) && scl0_oe_n);
   cover property ($rose(irq));
   cover property (!sda1_oe_n);
endmodule
bind i2cr_ctrl i2cr_properties i_i2cr_properties (.clk(clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .irq(irq),
   .stop_light(stop_light), .stop_deep(stop_deep), .sda0_oe_n(sda0_oe_n),
   .scl0_oe_n(scl0_oe_n), .sda1_oe_n(sda1_oe_n), .scl1_oe_n(scl1_oe_n));

// ---- testbench/i2cr_slave_model.sv ----
// Purpose: behavioural slave on the default pin pair
// Assumes: open-drain lines with pull-ups, write transfers only
// Notes: acks its address and data bytes, never stretches the clock
`timescale 1ns/1ps
module i2cr_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   input wire logic sda,
   input wire logic scl,
   output logic sda_oe_n
);
   logic [7:0] sh = 8'h00;
   logic act = 1'b0;
   logic adr = 1'b0;
   int n = 0;
   initial sda_oe_n = 1'b1;
   always @(sda) begin
      if (scl) begin
         act = !sda;
         adr = 1'b1;
         n = 0;
      end
   end
   always @(posedge scl) begin
      if (act && n < 8) begin
         sh = {sh[6:0], sda};
         n++;
      end
   end
   always @(negedge scl) begin
      if (act && n == 8) begin
         n = 9;
         if (adr && sh[7:1] != ADDR) act = 1'b0;
         else sda_oe_n = 1'b0;
      end else if (n == 9) begin
         sda_oe_n = 1'b1;
         n = 0;
         adr = 1'b0;
      end
   end
endmodule

// ---- testbench/tb.sv ----
// Purpose: self-checking bench of the two-wire controller
// Assumes: 40 MHz clock, slave model on the default pair
// Notes: hold counts allow three cycles of synchroniser lag
`timescale 1ns/1ps
`include "i2cr_defines.svh"
module tb;
   localparam logic [2:0] OW = `I2CR_OFS_OWN_ADDR, DV = `I2CR_OFS_RATE_DIV;
   localparam logic [2:0] CT = `I2CR_OFS_CTRL, ST = `I2CR_OFS_STAT, DT = `I2CR_OFS_DATA;
   localparam logic [2:0] MK = `I2CR_OFS_MASK, OP = `I2CR_OFS_SYS_OPT;
   logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic stop_light = 1'b0, stop_deep = 1'b0, ext_n = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, got;
   logic irq, s_oe_n, sda0_oe_n, scl0_oe_n, sda1_oe_n, scl1_oe_n;
   wire sda0 = sda0_oe_n & s_oe_n;
   wire sda1 = sda1_oe_n & ext_n;
   wire [4:0] pins = {irq, scl1_oe_n, sda1_oe_n, scl0_oe_n, sda0_oe_n};
   int fail_count = 0, tests_run = 0, n, m;
   always #12.5 clk = ~clk;
   i2cr_ctrl i_i2cr_ctrl (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .stop_light(stop_light), .stop_deep(stop_deep), .sda0_in(sda0),
      .sda0_out(), .sda0_oe_n(sda0_oe_n), .scl0_in(scl0_oe_n), .scl0_out(),
      .scl0_oe_n(scl0_oe_n), .sda1_in(sda1), .sda1_out(), .sda1_oe_n(sda1_oe_n),
      .scl1_in(scl1_oe_n), .scl1_out(), .scl1_oe_n(scl1_oe_n));
   i2cr_slave_model i_i2cr_slave_model (.sda(sda0), .scl(scl0_oe_n), .sda_oe_n(s_oe_n));
   task automatic give_verdict();
      $display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic rng(input int g, input int lo);
      chk({7'h00, g >= lo && g <= lo + 3}, 8'h01);
   endtask
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      got = reg_rdata;
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] k, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(got & k, e);
   endtask
   // counts edges until a pin reaches a level
   task automatic wt(input int b, input logic v, output int c);
      c = 0;
      while (pins[b] !== v) begin
         @(posedge clk);
         #1;
         c++;
         if (c > 5000) begin
            fail_count++;
            $display("mismatch at %0t: wait timed out", $time);
            give_verdict();
         end
      end
   endtask
   task automatic t_regs();
      for (int i = 0; i < 8; i++) rdc(3'(i), 8'hFF, 8'h00);
      bus(1'b1, OW, 8'h55);
      rdc(OW, 8'hFF, 8'h54);
      bus(1'b1, DV, 8'hC5);
      rdc(DV, 8'hFF, 8'hC5);
      bus(1'b1, 3'h7, 8'hFF);
      rdc(3'h7, 8'hFF, 8'h00);
      $display("register test done");
   endtask
   task automatic t_stop();
      bus(1'b1, MK, 8'h05);
      stop_light <= 1'b1;
      bus(1'b1, MK, 8'h0A);
      @(posedge clk);
      stop_light <= 1'b0;
      rdc(MK, 8'hFF, 8'h05);
      bus(1'b1, OW, 8'h55);
      @(posedge clk);
      stop_deep <= 1'b1;
      @(posedge clk);
      stop_deep <= 1'b0;
      rdc(OW, 8'hFF, 8'h00);
      rdc(MK, 8'hFF, 8'h00);
      $display("stop mode test done");
   endtask
   task automatic t_pins();
      bus(1'b1, CT, 8'h80);
      bus(1'b1, OP, 8'h01);
      ext_n <= 1'b0;
      repeat (5) @(posedge clk);
      bus(1'b1, CT, 8'hB0);
      rdc(ST, 8'h82, 8'h82);
      rdc(CT, 8'h20, 8'h00);
      chk({7'h00, sda1_oe_n}, 8'h01);
      chk({7'h00, irq}, 8'h00);
      bus(1'b1, MK, 8'h02);
      chk({7'h00, irq}, 8'h01);
      bus(1'b1, MK, 8'h00);
      chk({7'h00, irq}, 8'h00);
      ext_n <= 1'b1;
      bus(1'b1, ST, 8'h0F);
      bus(1'b1, CT, 8'hB0);
      wt(2, 1'b0, n);
      chk({7'h00, sda0_oe_n}, 8'h01);
      wt(3, 1'b0, n);
      bus(1'b1, CT, 8'hB4);
      wt(2, 1'b1, n);
      wt(3, 1'b1, n);
      wt(2, 1'b0, n);
      chk({7'h00, scl1_oe_n}, 8'h01);
      wt(3, 1'b0, n);
      bus(1'b1, CT, 8'h90);
      wt(2, 1'b1, n);
      bus(1'b1, OP, 8'h00);
      $display("pin and arbitration test done");
   endtask
   task automatic t_rate(input logic [7:0] d, input int ml, dv, hd, hs, hp);
      bus(1'b1, DV, d);
      bus(1'b1, MK, 8'h01);
      bus(1'b1, CT, 8'hB0);
      wt(0, 1'b0, n);
      wt(1, 1'b0, n);
      rng(n, hs * ml);
      bus(1'b1, DT, 8'h54);
      wt(1, 1'b1, n);
      wt(1, 1'b0, n);
      wt(0, 1'b1, n);
      rng(n, hd * ml);
      wt(1, 1'b1, m);
      rng(n + m, dv * ml / 2);
      wt(4, 1'b1, n);
      rdc(ST, 8'h91, 8'h81);
      bus(1'b1, ST, 8'h0F);
      bus(1'b1, CT, 8'h90);
      chk({7'h00, irq}, 8'h00);
      wt(1, 1'b1, n);
      wt(0, 1'b1, n);
      rng(n, hp * ml);
      $display("rate test %h done", d);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_stop();
      t_pins();
      t_rate(8'h00, 1, 20, 7, 6, 11);
      t_rate(8'h47, 2, 40, 10, 16, 21);
      t_rate(8'h81, 4, 22, 7, 7, 12);
      t_rate(8'hC0, 1, 20, 7, 6, 11);
      give_verdict();
   end
endmodule
